// >>> common/cof_consts.vh
// Constants for the communication-option fault handler
`ifndef COF_CONSTS_VH
`define COF_CONSTS_VH
// Stop actions
`define COF_ACT_RAMP 2'h0
`define COF_ACT_COAST 2'h1
`define COF_ACT_FAST 2'h2
`define COF_ACT_ALARM 2'h3
// Setting defaults and limits
`define COF_DEF_ERR_ACTION 2'h1
`define COF_DEF_EXT_DETECT 1'h0
`define COF_DEF_EXT_ACTION 2'h1
`define COF_DEF_MULTISTEP 1'h0
`define COF_DEF_RESET_INIT 1'h0
`define COF_DEF_DELAY_TENTHS 6'h14
`define COF_MAX_DELAY_TENTHS 6'h32
`define COF_DEF_NODE_ADDR 7'h00
`define COF_MAX_NODE_ADDR 7'h40
`define COF_DEF_SPEED_CODE 3'h0
`define COF_MAX_SPEED_CODE 3'h4
`define COF_DEF_AUTO_RESET 1'h0
// Link speed codes
`define COF_SPD_156K 3'h0
`define COF_SPD_625K 3'h1
`define COF_SPD_2M5 3'h2
`define COF_SPD_5M 3'h3
`define COF_SPD_10M 3'h4
// Timing: clock rate and delay unit
`define COF_CLK_HZ 40000000
`define COF_TENTH_MS 100
`define COF_TENTH_CYCLES ((`COF_CLK_HZ / 1000) * `COF_TENTH_MS)
`endif

// >>> testbench/cof_handler_monitor.sv
// Assertion checker bound to the fault handler ports
`timescale 1ns/1ps
`default_nettype none
module cof_mon #(
    parameter TENTH_CYCLES = 10
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire profile_active_in,
    input wire comm_lost_in,
    input wire fault_retry_in,
    input wire multistep_active_in,
    input wire network_reference_select_in,
    input wire bus_error_out,
    input wire use_multistep_ref_out,
    input wire [6:0] node_address_out,
    input wire [2:0] link_speed_out,
    input wire link_speed_valid_out
);
    localparam int LIM = 50 * TENTH_CYCLES + 9;
    logic [15:0] wait_ff;
    // Cycles of unbroken link loss with no bus error yet
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            wait_ff <= 16'h0000;
        else if (!comm_lost_in || !profile_active_in || bus_error_out)
            wait_ff <= 16'h0000;
        else
            wait_ff <= wait_ff + 16'h0001;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_clear_cause;
        $past(fault_retry_in) || $past(fault_retry_in, 2) || !$past(profile_active_in);
    endsequence
    property p_valid; $past(rst_n_in) |-> link_speed_valid_out == $past(profile_active_in); endproperty
    a_valid: assert property (p_valid) else $error("speed valid not tracking profile");
    property p_node_off; !$past(profile_active_in) |-> node_address_out == 7'h00; endproperty
    a_node_off: assert property (p_node_off) else $error("node shown while inactive");
    property p_node_max; node_address_out <= 7'h40; endproperty
    a_node_max: assert property (p_node_max) else $error("node address above range");
    property p_spd_max; link_speed_out <= 3'h4; endproperty
    a_spd_max: assert property (p_spd_max) else $error("speed code above range");
    property p_bus_hold; $fell(bus_error_out) |-> s_clear_cause; endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus error dropped on its own");
    property p_ms_need; use_multistep_ref_out |-> $past(multistep_active_in); endproperty
    a_ms_need: assert property (p_ms_need) else $error("multistep used while idle");
    property p_ms_free;
        $past(rst_n_in && multistep_active_in && !network_reference_select_in) |-> use_multistep_ref_out;
    endproperty
    a_ms_free: assert property (p_ms_free) else $error("multistep lost off network ref");
    property p_bus_lim; wait_ff <= LIM; endproperty
    a_bus_lim: assert property (p_bus_lim) else $error("bus error late");
endmodule // cof_mon
bind cof_handler cof_mon #(.TENTH_CYCLES(TENTH_CYCLES)) u_mon (.*);
`default_nettype wire

// >>> testbench/cof_handler_test.sv
// Self-checking bench for the comm-option fault handler
`timescale 1ns/1ps
`default_nettype none
module cof_handler_test;
    logic clk_in = '0, rst_n_in = '0, clk_en_in = '1, set_load_in = '0, comm_error_in = '0;
    logic [1:0] comm_error_action_select_in = '0, ext_fault_action_select_in = '0;
    logic ext_fault_detect_select_in = '0, net_ref_multistep_select_in = '0;
    logic comm_param_reset_on_init_in = '0, bus_error_auto_reset_in = '0, fault_retry_in = '0;
    logic initialization_command_in = '0, profile_active_in = '0, drive_running_in = '0;
    logic network_reference_select_in = '0, multistep_active_in = '0, pb = '0, pe = '0;
    logic [5:0] bus_error_delay_in = '0;
    logic [6:0] station_node_address_in = '0, v, node_address_out;
    logic [2:0] link_speed_code_in = '0, link_speed_out;
    logic lost_req = '0, fault_req = '0, comm_lost_in, option_external_fault_in;
    logic stop_request_out, alarm_out, bus_error_out, ext_fault_out, comm_fault_out;
    logic use_multistep_ref_out, link_speed_valid_out;
    logic [1:0] stop_action_out;
    logic [3:0] e, exp_q[$];
    int errors = 0, num_checks = 0, cycles = 0, seed = 32'h0552ca1f, i;
    cof_handler #(.TENTH_CYCLES(10)) u_dut (.*);
    cof_master_model u_net (.lost_req_in(lost_req), .fault_req_in(fault_req),
        .comm_lost_out(comm_lost_in), .ext_fault_out(option_external_fault_in));
    always #12.5 clk_in = ~clk_in;
    task automatic check(string what, logic [6:0] seen, logic [6:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
        cyc(3);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // Stop reaction noted by the driver, compared when a fault appears
    always @(negedge clk_in) begin
        if ((bus_error_out && !pb) || (ext_fault_out && !pe)) begin
            e = exp_q.pop_front();
            check("req", stop_request_out, e[3]);
            check("alarm", alarm_out, e[2]);
            if (e[3]) check("act", stop_action_out, e[1:0]);
        end
        pb = bus_error_out;
        pe = ext_fault_out;
    end
    initial begin
        cyc(16);
        check("rst_act", stop_action_out, 2'h1);
        rst_n_in = 1'h1;
        profile_active_in = 1'h1;
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 7'h40 : (i == 5) ? v : 7'({$random(seed)} % 65);
            station_node_address_in = (i == 5) ? 7'h41 + 7'({$random(seed)} % 63) : v;
            link_speed_code_in = (i == 5) ? 3'h5 : 3'(i);
            pulse(set_load_in);
            check("node", node_address_out, v);
            check("speed", link_speed_out, (i == 5) ? 3'h4 : 3'(i));
            check("valid", link_speed_valid_out, 1'h1);
        end
        profile_active_in = 1'h0;
        cyc(2);
        check("node_off", node_address_out, 7'h00);
        profile_active_in = 1'h1;
        $display("settings test done");
        for (i = 0; i < 4; i++) begin
            comm_error_action_select_in = 2'(i);
            bus_error_delay_in = 6'(i);
            bus_error_auto_reset_in = i[0];
            pulse(set_load_in);
            exp_q.push_back((i == 3) ? 4'h4 : {2'h2, 2'(i)});
            lost_req = 1'h1;
            cyc(i * 10);
            check("early", bus_error_out, 1'h0);
            repeat (40) if (bus_error_out !== 1'h1) cyc(1);
            check("bus_err", bus_error_out, 1'h1);
            lost_req = 1'h0;
            cyc(8);
            pulse(fault_retry_in);
            check("retry", bus_error_out, !i[0]);
            bus_error_auto_reset_in = 1'h1;
            pulse(set_load_in);
            pulse(fault_retry_in);
        end
        bus_error_delay_in = 6'h02;
        pulse(set_load_in);
        repeat (2) begin
            lost_req = 1'h1;
            cyc(14);
            lost_req = 1'h0;
            cyc(8);
        end
        check("recover", bus_error_out, 1'h0);
        $display("bus error test done");
        network_reference_select_in = 1'h1;
        multistep_active_in = 1'h1;
        for (i = 0; i < 2; i++) begin
            net_ref_multistep_select_in = i[0];
            pulse(set_load_in);
            check("ms", use_multistep_ref_out, i[0]);
        end
        network_reference_select_in = 1'h0;
        for (i = 0; i < 2; i++) begin
            comm_param_reset_on_init_in = i[0];
            station_node_address_in = 7'h09;
            pulse(set_load_in);
            pulse(initialization_command_in);
            check("init", node_address_out, i ? 7'h00 : 7'h09);
            check("init_spd", link_speed_out, i ? 3'h0 : 3'h4);
        end
        $display("multistep and init tests done");
        ext_fault_detect_select_in = 1'h1;
        ext_fault_action_select_in = 2'h2;
        pulse(set_load_in);
        fault_req = 1'h1;
        cyc(10);
        check("ef_idle", ext_fault_out, 1'h0);
        exp_q.push_back(4'ha);
        drive_running_in = 1'h1;
        repeat (10) if (ext_fault_out !== 1'h1) cyc(1);
        check("ef_run", ext_fault_out, 1'h1);
        fault_req = 1'h0;
        drive_running_in = 1'h0;
        cyc(6);
        pulse(fault_retry_in);
        check("ef_clr", ext_fault_out, 1'h0);
        check("pending", 7'(exp_q.size()), 7'h00);
        $display("external fault test done");
        report_and_stop();
    end
endmodule // cof_handler_test
`default_nettype wire

// >>> testbench/cof_master_model.sv
// Network side stand-in driving link loss and option fault pins
`timescale 1ns/1ps
`default_nettype none
module cof_master_model (
    input wire logic lost_req_in,
    input wire logic fault_req_in,
    output logic comm_lost_out = 1'h0,
    output logic ext_fault_out = 1'h0
);
    // Pins move mid-cycle, unrelated to the drive clock
    always @(lost_req_in) comm_lost_out <= #7 lost_req_in;
    always @(fault_req_in) ext_fault_out <= #11 fault_req_in;
endmodule // cof_master_model
`default_nettype wire

// >>> verilog/cof_handler.v
// Communication-option fault supervision logic of a motor drive
//
// Notes on behaviour
// - Comm error reaction: 0 ramp, 1 coast, 2 fast stop, 3 alarm; default coast.
// - Option external fault detected always (0) or only while running (1).
// - Option external fault reaction: ramp, coast, fast stop or alarm; default coast.
// - Selection 0: multi-step references ignored while network reference selected.
// - Selection 1: multi-step inputs stay active and override network reference.
// - Initialization restores comm settings to defaults only when reset selection is 1.
// - The reset selection itself is never restored by initialization.
// - Bus error declared after programmable delay 0.0 to 5.0 s, default 2.0 s.
// - Station node address presented from setting 0 to 64, default 0.
// - Link speed code 0..4 selects 156k, 625k, 2.5M, 5M, 10M bit rate.
// - Bus error auto-retry clears it only when auto-reset selection is 1.
// - Delay, address, speed, auto-reset apply only to the one fieldbus profile.
`timescale 1ns/1ps
`default_nettype none
`include "cof_consts.vh"

module cof_handler #(
    parameter TENTH_CYCLES = `COF_TENTH_CYCLES
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire clk_en_in,
    input wire set_load_in,
    input wire [1:0] comm_error_action_select_in,
    input wire ext_fault_detect_select_in,
    input wire [1:0] ext_fault_action_select_in,
    input wire net_ref_multistep_select_in,
    input wire comm_param_reset_on_init_in,
    input wire [5:0] bus_error_delay_in,
    input wire [6:0] station_node_address_in,
    input wire [2:0] link_speed_code_in,
    input wire bus_error_auto_reset_in,
    input wire initialization_command_in,
    input wire profile_active_in,
    input wire comm_lost_in,
    input wire comm_error_in,
    input wire option_external_fault_in,
    input wire drive_running_in,
    input wire network_reference_select_in,
    input wire multistep_active_in,
    input wire fault_retry_in,
    output reg [1:0] stop_action_out,
    output reg stop_request_out,
    output reg alarm_out,
    output reg bus_error_out,
    output reg ext_fault_out,
    output reg comm_fault_out,
    output reg use_multistep_ref_out,
    output reg [6:0] node_address_out,
    output reg [2:0] link_speed_out,
    output reg link_speed_valid_out
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    reg [2:0] lost_sync_ff;
    reg [2:0] ext_sync_ff;
    reg lost_ff;
    reg ext_ff;
    wire nxt_lost;
    wire nxt_ext;
    assign nxt_lost = (lost_sync_ff[1] == lost_sync_ff[2]) ? lost_sync_ff[2] : lost_ff;
    assign nxt_ext = (ext_sync_ff[1] == ext_sync_ff[2]) ? ext_sync_ff[2] : ext_ff;

    // Link loss pin: three stages, a change counts once stages two and three agree
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lost_sync_ff <= 3'h0;
            lost_ff <= 1'b0;
        end else if (clk_en_in) begin
            lost_sync_ff <= {lost_sync_ff[1:0], comm_lost_in};
            lost_ff <= nxt_lost;
        end
    end

    // Option fault pin, same scheme
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_sync_ff <= 3'h0;
            ext_ff <= 1'b0;
        end else if (clk_en_in) begin
            ext_sync_ff <= {ext_sync_ff[1:0], option_external_fault_in};
            ext_ff <= nxt_ext;
        end
    end

    // ****************************************
    // Settings store
    // ****************************************
    reg [1:0] err_act_ff;
    reg ext_det_ff;
    reg [1:0] ext_act_ff;
    reg mstep_ff;
    reg rst_init_ff;
    reg [5:0] delay_ff;
    reg [6:0] node_ff;
    reg [2:0] speed_ff;
    reg auto_rst_ff;
    wire node_ok;
    wire speed_ok;
    // Out-of-range address or speed codes leave the stored value alone
    assign node_ok = (station_node_address_in <= `COF_MAX_NODE_ADDR);
    assign speed_ok = (link_speed_code_in <= `COF_MAX_SPEED_CODE);

    function [5:0] clip_delay;
        input [5:0] v;
        begin
            clip_delay = (v > `COF_MAX_DELAY_TENTHS) ? `COF_MAX_DELAY_TENTHS : v;
        end
    endfunction

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_act_ff <= `COF_DEF_ERR_ACTION;
            ext_det_ff <= `COF_DEF_EXT_DETECT;
            ext_act_ff <= `COF_DEF_EXT_ACTION;
            mstep_ff <= `COF_DEF_MULTISTEP;
            rst_init_ff <= `COF_DEF_RESET_INIT;
            delay_ff <= `COF_DEF_DELAY_TENTHS;
            node_ff <= `COF_DEF_NODE_ADDR;
            speed_ff <= `COF_DEF_SPEED_CODE;
            auto_rst_ff <= `COF_DEF_AUTO_RESET;
        end else if (clk_en_in) begin
            if (initialization_command_in) begin
                if (rst_init_ff) begin
                    err_act_ff <= `COF_DEF_ERR_ACTION;
                    ext_det_ff <= `COF_DEF_EXT_DETECT;
                    ext_act_ff <= `COF_DEF_EXT_ACTION;
                    mstep_ff <= `COF_DEF_MULTISTEP;
                    delay_ff <= `COF_DEF_DELAY_TENTHS;
                    node_ff <= `COF_DEF_NODE_ADDR;
                    speed_ff <= `COF_DEF_SPEED_CODE;
                    auto_rst_ff <= `COF_DEF_AUTO_RESET;
                end
                // Reset selection held through initialization
            end else if (set_load_in) begin
                err_act_ff <= comm_error_action_select_in;
                ext_det_ff <= ext_fault_detect_select_in;
                ext_act_ff <= ext_fault_action_select_in;
                mstep_ff <= net_ref_multistep_select_in;
                rst_init_ff <= comm_param_reset_on_init_in;
                delay_ff <= clip_delay(bus_error_delay_in);
                if (node_ok) begin
                    node_ff <= station_node_address_in;
                end
                if (speed_ok) begin
                    speed_ff <= link_speed_code_in;
                end
                auto_rst_ff <= bus_error_auto_reset_in;
            end
        end
    end

    // ****************************************
    // Bus error delay timer
    // ****************************************
    reg [31:0] cyc_ff;
    reg [5:0] tenth_ff;
    reg bus_err_ff;
    wire tick;
    wire expired;
    wire loss_seen;
    wire [31:0] nxt_cyc;
    wire [5:0] nxt_tenth;
    assign tick = (cyc_ff == TENTH_CYCLES - 1);
    assign expired = (tenth_ff >= delay_ff);
    assign loss_seen = profile_active_in && lost_ff;
    assign nxt_cyc = cyc_ff + 32'h1;
    assign nxt_tenth = tenth_ff + 6'h1;

    // Tenth-of-second counter, zeroed whenever the link is back
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cyc_ff <= 32'h0;
            tenth_ff <= 6'h0;
        end else if (clk_en_in) begin
            if (!loss_seen) begin
                cyc_ff <= 32'h0;
                tenth_ff <= 6'h0;
            end else if (!expired) begin
                if (tick) begin
                    cyc_ff <= 32'h0;
                    tenth_ff <= nxt_tenth;
                end else begin
                    cyc_ff <= nxt_cyc;
                end
            end
        end
    end

    // ****************************************
    // Bus error flag
    // ****************************************
    // A new expiry beats a retry in the same cycle
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_err_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (loss_seen && expired) begin
                bus_err_ff <= 1'b1;
            end else if (fault_retry_in && auto_rst_ff) begin
                bus_err_ff <= 1'b0;
            end else if (!profile_active_in) begin
                bus_err_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Fault reaction
    // ****************************************
    reg ext_lat_ff;
    wire ext_seen;
    wire ext_active;
    wire comm_ev;
    wire ext_stops;
    wire comm_stops;
    assign ext_seen = ext_ff && (!ext_det_ff || drive_running_in);
    assign ext_active = ext_seen || ext_lat_ff;
    assign comm_ev = comm_error_in || bus_err_ff;

    function stop_of;
        input [1:0] act;
        begin
            stop_of = (act != `COF_ACT_ALARM);
        end
    endfunction

    assign ext_stops = ext_active && stop_of(ext_act_ff);
    assign comm_stops = comm_ev && stop_of(err_act_ff);

    // ****************************************
    // External fault latch
    // ****************************************
    // A new fault beats a retry in the same cycle
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_lat_ff <= 1'b0;
        end else if (clk_en_in) begin
            if (ext_seen) begin
                ext_lat_ff <= 1'b1;
            end else if (fault_retry_in) begin
                ext_lat_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Stop reaction outputs
    // ****************************************
    // External fault takes precedence in action choice
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stop_action_out <= `COF_ACT_COAST;
            stop_request_out <= 1'b0;
            alarm_out <= 1'b0;
        end else if (clk_en_in) begin
            if (ext_active) begin
                stop_action_out <= ext_act_ff;
            end else begin
                stop_action_out <= err_act_ff;
            end
            stop_request_out <= ext_stops || comm_stops;
            alarm_out <= (ext_active && !ext_stops) || (comm_ev && !comm_stops);
        end
    end

    // ****************************************
    // Fault status outputs
    // ****************************************
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_error_out <= 1'b0;
            ext_fault_out <= 1'b0;
            comm_fault_out <= 1'b0;
        end else if (clk_en_in) begin
            bus_error_out <= bus_err_ff;
            ext_fault_out <= ext_active;
            comm_fault_out <= comm_ev;
        end
    end

    // ****************************************
    // Reference and link outputs
    // ****************************************
    // Multi-step precedence over network reference
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            use_multistep_ref_out <= 1'b0;
            node_address_out <= `COF_DEF_NODE_ADDR;
            link_speed_out <= `COF_DEF_SPEED_CODE;
            link_speed_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            use_multistep_ref_out <= multistep_active_in &&
                (!network_reference_select_in || mstep_ff);
            node_address_out <= profile_active_in ? node_ff : `COF_DEF_NODE_ADDR;
            link_speed_out <= speed_ff;
            link_speed_valid_out <= profile_active_in;
        end
    end

endmodule // cof_handler
`default_nettype wire
